/* File: hw/s2i_pkg.sv */
// Purpose: shared constants and types of the serial-link to two-wire bus bridge
// Assumes: system clock of 200 MHz, two-wire bus clock of 100 kHz by default
// Notes:   command codes other than the all-zero null are one-hot bytes; the status byte carries the acknowledge in bit 0
package s2i_pkg;

   // =====================================================================
   // timing
   localparam int unsigned SYS_CLK_HZ      = 200_000_000;
   localparam int unsigned SCL_HZ          = 100_000;
   // one quarter of a bus clock period, in system cycles
   localparam int unsigned SCL_QUARTER_CYC = SYS_CLK_HZ / (4 * SCL_HZ);

   // =====================================================================
   // link word layout
   localparam logic [4:0] SPI_WORD_BITS = 5'h10;
   localparam logic [4:0] SPI_LAST_BIT  = 5'h0f;

   // =====================================================================
   // bus_command values
   localparam logic [7:0] CMD_START = 8'h80;
   localparam logic [7:0] CMD_WRITE = 8'h40;
   localparam logic [7:0] CMD_READ  = 8'h20;
   localparam logic [7:0] CMD_STOP  = 8'h10;
   localparam logic [7:0] CMD_NULL  = 8'h00;

   // =====================================================================
   // bridge_status fields and reset values
   localparam int         ST_ACK_POS    = 0;
   localparam int         ST_BADCMD_POS = 1;
   localparam int         ST_DROP_POS   = 2;
   localparam int         ST_BUSY_POS   = 7;
   localparam logic [7:0] DATA_OUT_RST  = 8'h00;
   localparam logic [7:0] READ_FILL     = 8'hff;

   // =====================================================================
   // bit-cell quarters
   localparam logic [1:0] PH_DRIVE  = 2'h0;
   localparam logic [1:0] PH_RISE   = 2'h1;
   localparam logic [1:0] PH_SAMPLE = 2'h2;
   localparam logic [1:0] PH_FALL   = 2'h3;
   localparam logic [2:0] BIT_MSB   = 3'h7;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_START = 5'h02,
      ST_BIT   = 5'h04,
      ST_ACK   = 5'h08,
      ST_STOP  = 5'h10
   } s2i_state_type;

   // true for every command byte that the bridge knows
   function automatic logic s2i_cmd_known(input logic [7:0] cmd);
      return (cmd == CMD_START) || (cmd == CMD_WRITE) || (cmd == CMD_READ) ||
             (cmd == CMD_STOP)  || (cmd == CMD_NULL);
   endfunction

endpackage

/* File: hw/s2i_sync.sv */
// Purpose: two-flop synchroniser for one level into the system clock
// Assumes: input is asynchronous to clock
// Notes:   only the second flop is visible outside
`timescale 1ns/1ps
module s2i_sync
   import s2i_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic din,
   output logic      dout
);

   logic meta_ff;
   logic hold_ff;

   // =====================================================================
   // double registering
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_ff <= 1'b0;
         hold_ff <= 1'b0;
      end else begin
         meta_ff <= din;
         hold_ff <= meta_ff;
      end
   end

   assign dout = hold_ff;

endmodule

/* File: hw/s2i_spi_link.sv */
// Purpose: serial-link slave shifter running on the host's serial clock
// Assumes: clock idle low, sample on rising edge, shift on falling edge, msb first
// Notes:   the clock stops between words, so select high clears the bit counter
`timescale 1ns/1ps
module s2i_spi_link
   import s2i_pkg::*;
(
   input  wire logic        spiClk,
   input  wire logic        rst,
   input  wire logic        ssN,
   input  wire logic        mosi,
   input  wire logic [15:0] txWord,
   output logic             miso,
   output logic [15:0]      rxWord,
   output logic             wordTog
);

   logic [4:0]  bitCnt_ff;
   logic [14:0] rxSh_ff;
   logic [15:0] rxWord_ff;
   logic        wordTog_ff;
   logic        misoBit_ff;
   wire         lastBit = (bitCnt_ff == SPI_LAST_BIT);
   wire         inWord  = (bitCnt_ff < SPI_WORD_BITS);
   wire  [3:0]  nxtIdx  = 4'(SPI_LAST_BIT - bitCnt_ff);

   // =====================================================================
   // bit counter; saturates so extra clocks never form a second word
   always_ff @(posedge spiClk or posedge ssN) begin
      if (ssN) begin
         bitCnt_ff <= 5'h00;
      end else if (inWord) begin
         bitCnt_ff <= bitCnt_ff + 5'h01;
      end
   end

   // receive shifter, msb first
   always_ff @(posedge spiClk) begin
      rxSh_ff <= {rxSh_ff[13:0], mosi};
   end

   // whole word captured on the sixteenth rising edge only
   always_ff @(posedge spiClk or posedge rst) begin
      if (rst) begin
         rxWord_ff  <= 16'h0000;
         wordTog_ff <= 1'b0;
      end else if (!ssN && lastBit) begin
         rxWord_ff  <= {rxSh_ff, mosi};
         wordTog_ff <= ~wordTog_ff;
      end
   end

   // transmit bit moves on the falling edge
   always_ff @(negedge spiClk or posedge ssN) begin
      if (ssN) begin
         misoBit_ff <= 1'b0;
      end else begin
         misoBit_ff <= inWord ? txWord[nxtIdx] : 1'b0;
      end
   end

   // first bit must stand before any clock edge, so it bypasses the flop
   assign miso    = (bitCnt_ff == 5'h00) ? txWord[15] : misoBit_ff;
   assign rxWord  = rxWord_ff;
   assign wordTog = wordTog_ff;

endmodule

/* File: hw/s2i_bridge.sv */
// Purpose: serial-link slave to two-wire bus master bridge
// Assumes: host waits after select rises until the bus operation is over
// Notes:   sole bus master; the bus clock is only ever driven, never read back
`timescale 1ns/1ps
module s2i_bridge
   import s2i_pkg::*;
#(
   parameter int unsigned CLK_DIV = SCL_QUARTER_CYC
)(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic spiClk,
   input  wire logic ssN,
   input  wire logic mosi,
   output logic      miso,
   output logic      sclOut,
   input  wire logic sdaIn,
   output logic      sdaOut,
   output logic      sdaOeN
);

   // =====================================================================
   // declarations
   localparam logic [15:0] DIV_LAST     = 16'(CLK_DIV - 1);
   localparam int          SCL_HIGH_CYC = 2 * CLK_DIV;

   s2i_state_type state_ff;
   s2i_state_type nxt_state;
   logic [1:0]    phase_ff;
   logic [1:0]    nxt_phase;
   logic [2:0]    bitIdx_ff;
   logic [2:0]    nxt_bitIdx;
   logic [7:0]    shift_ff;
   logic [7:0]    nxt_shift;
   logic [7:0]    dataOut_ff;
   logic [7:0]    nxt_dataOut;
   logic [15:0]   divCnt_ff;
   logic [15:0]   sclHiCnt_ff;
   logic          rdOp_ff;
   logic          nxt_rdOp;
   logic          sclOut_ff;
   logic          nxt_sclOut;
   logic          sdaLow_ff;
   logic          nxt_sdaLow;
   logic          ack_ff;
   logic          nxt_ack;
   logic          badCmd_ff;
   logic          nxt_badCmd;
   logic          drop_ff;
   logic          nxt_drop;
   logic          ssDly_ff;
   logic          togSeen_ff;
   logic          ssSync;
   logic          togSync;
   logic          sdaSync;
   logic          wordTog;
   logic [15:0]   rxWord;
   logic [7:0]    status;

   // =====================================================================
   // link side on its own clock
   s2i_spi_link u_link (
      .spiClk  (spiClk),
      .rst     (rst),
      .ssN     (ssN),
      .mosi    (mosi),
      .txWord  ({status, dataOut_ff}),
      .miso    (miso),
      .rxWord  (rxWord),
      .wordTog (wordTog)
   );

   // crossings: select level, word toggle and the bus data pin
   s2i_sync u_syncSs (
      .clock (clock),
      .rst   (rst),
      .din   (ssN),
      .dout  (ssSync)
   );

   s2i_sync u_syncTog (
      .clock (clock),
      .rst   (rst),
      .din   (wordTog),
      .dout  (togSync)
   );

   s2i_sync u_syncSda (
      .clock (clock),
      .rst   (rst),
      .din   (sdaIn),
      .dout  (sdaSync)
   );

   // =====================================================================
   // word decode; the captured word is quiet once select has risen
   wire       ssRise  = ssSync & ~ssDly_ff;
   wire       fresh   = togSync ^ togSeen_ff;
   wire       accept  = ssRise & fresh;
   wire       isIdle  = (state_ff == ST_IDLE);
   wire       startOp = accept & isIdle;
   wire [7:0] rxCmd   = rxWord[15:8];
   wire [7:0] rxData  = rxWord[7:0];
   wire       tick    = (divCnt_ff == DIV_LAST);

   // status byte; read by the link domain while static between words
   assign status = {~isIdle, 4'h0, drop_ff, badCmd_ff, ack_ff};

   // open-drain data: only ever pull low, never drive high
   assign sdaOut = 1'b0;
   assign sdaOeN = ~sdaLow_ff;
   assign sclOut = sclOut_ff;

   // =====================================================================
   // bus sequencer, advanced one quarter bit at a time
   always_comb begin
      nxt_state   = state_ff;
      nxt_phase   = phase_ff;
      nxt_bitIdx  = bitIdx_ff;
      nxt_shift   = shift_ff;
      nxt_dataOut = dataOut_ff;
      nxt_rdOp    = rdOp_ff;
      nxt_sclOut  = sclOut_ff;
      nxt_sdaLow  = sdaLow_ff;
      nxt_ack     = ack_ff;
      nxt_badCmd  = badCmd_ff;
      nxt_drop    = drop_ff;
      // a word arriving while busy breaks the host's wait; flag it, drop it
      if (accept && !isIdle) begin
         nxt_drop = 1'b1;
      end
      if (startOp) begin
         nxt_badCmd = ~s2i_cmd_known(rxCmd);
         nxt_drop   = 1'b0;
         nxt_phase  = PH_DRIVE;
         nxt_bitIdx = BIT_MSB;
         nxt_rdOp   = 1'b0;
         case (rxCmd)
            CMD_START: begin
               nxt_state = ST_START;
               nxt_shift = rxData;
            end
            CMD_WRITE: begin
               nxt_state = ST_BIT;
               nxt_shift = rxData;
            end
            CMD_READ: begin
               nxt_state = ST_BIT;
               nxt_shift = READ_FILL;
               nxt_rdOp  = 1'b1;
            end
            CMD_STOP: begin
               nxt_state = ST_STOP;
            end
            default: begin
               nxt_state = ST_IDLE;
            end
         endcase
      end else if (tick && !isIdle) begin
         nxt_phase = phase_ff + 2'h1;
         case (state_ff)
            ST_START: begin
               // release, raise clock, pull data low under high clock
               case (phase_ff)
                  PH_DRIVE:  nxt_sdaLow = 1'b0;
                  PH_RISE:   nxt_sclOut = 1'b1;
                  PH_SAMPLE: nxt_sdaLow = 1'b1;
                  default: begin
                     nxt_sclOut = 1'b0;
                     nxt_state  = ST_BIT;
                  end
               endcase
            end
            ST_BIT: begin
               case (phase_ff)
                  PH_DRIVE:  nxt_sdaLow = ~rdOp_ff & ~shift_ff[7];
                  PH_RISE:   nxt_sclOut = 1'b1;
                  PH_SAMPLE: begin
                     if (rdOp_ff) begin
                        nxt_shift = {shift_ff[6:0], sdaSync};
                     end
                  end
                  default: begin
                     nxt_sclOut = 1'b0;
                     if (!rdOp_ff) begin
                        nxt_shift = {shift_ff[6:0], 1'b0};
                     end
                     if (bitIdx_ff == 3'h0) begin
                        nxt_state = ST_ACK;
                     end else begin
                        nxt_bitIdx = bitIdx_ff - 3'h1;
                     end
                  end
               endcase
            end
            ST_ACK: begin
               // released line: slave acks a write, master nacks a read
               case (phase_ff)
                  PH_DRIVE:  nxt_sdaLow = 1'b0;
                  PH_RISE:   nxt_sclOut = 1'b1;
                  PH_SAMPLE: begin
                     if (!rdOp_ff) begin
                        nxt_ack = ~sdaSync;
                     end
                  end
                  default: begin
                     nxt_sclOut = 1'b0;
                     nxt_state  = ST_IDLE;
                     if (rdOp_ff) begin
                        nxt_dataOut = shift_ff;
                     end
                  end
               endcase
            end
            ST_STOP: begin
               // clock low first so pulling data low is never a start
               case (phase_ff)
                  PH_DRIVE:  nxt_sclOut = 1'b0;
                  PH_RISE:   nxt_sdaLow = 1'b1;
                  PH_SAMPLE: nxt_sclOut = 1'b1;
                  default: begin
                     nxt_sdaLow = 1'b0;
                     nxt_state  = ST_IDLE;
                  end
               endcase
            end
            default: begin
               nxt_state = ST_IDLE;
            end
         endcase
      end
   end

   // =====================================================================
   // state registers
   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff   <= ST_IDLE;
         phase_ff   <= PH_DRIVE;
         bitIdx_ff  <= BIT_MSB;
         shift_ff   <= DATA_OUT_RST;
         dataOut_ff <= DATA_OUT_RST;
         rdOp_ff    <= 1'b0;
         sclOut_ff  <= 1'b1;
         sdaLow_ff  <= 1'b0;
         ack_ff     <= 1'b0;
         badCmd_ff  <= 1'b0;
         drop_ff    <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         phase_ff   <= nxt_phase;
         bitIdx_ff  <= nxt_bitIdx;
         shift_ff   <= nxt_shift;
         dataOut_ff <= nxt_dataOut;
         rdOp_ff    <= nxt_rdOp;
         sclOut_ff  <= nxt_sclOut;
         sdaLow_ff  <= nxt_sdaLow;
         ack_ff     <= nxt_ack;
         badCmd_ff  <= nxt_badCmd;
         drop_ff    <= nxt_drop;
      end
   end

   // divider restarts with each operation so the first quarter is full
   always_ff @(posedge clock) begin
      if (rst || tick || startOp) begin
         divCnt_ff <= 16'h0000;
      end else begin
         divCnt_ff <= divCnt_ff + 16'h0001;
      end
   end

   // select edge history and the last word toggle seen
   always_ff @(posedge clock) begin
      if (rst) begin
         ssDly_ff   <= 1'b0;
         togSeen_ff <= 1'b0;
      end else begin
         ssDly_ff   <= ssSync;
         togSeen_ff <= ssRise ? togSync : togSeen_ff;
      end
   end

   // counts bus clock high time, only for checking
   always_ff @(posedge clock) begin
      if (rst || !sclOut_ff) begin
         sclHiCnt_ff <= 16'h0000;
      end else begin
         sclHiCnt_ff <= sclHiCnt_ff + 16'h0001;
      end
   end

   // =====================================================================
   // checks
   AST_CMD_STARTS_OP: assert property (@(posedge clock) disable iff (rst)
      startOp && (rxCmd != CMD_NULL) && s2i_cmd_known(rxCmd) |=> !isIdle)
      else $error("known command did not start a bus operation");

   AST_NULL_STAYS_IDLE: assert property (@(posedge clock) disable iff (rst)
      startOp && (rxCmd == CMD_NULL) |=> isIdle && $stable(sclOut_ff) && $stable(sdaLow_ff))
      else $error("null command disturbed the bus");

   AST_START_EDGE: assert property (@(posedge clock) disable iff (rst)
      (state_ff == ST_START) && tick && (phase_ff == PH_SAMPLE)
      |=> sdaLow_ff && sclOut_ff ##[1:1000] (state_ff == ST_BIT))
      else $error("start condition not formed under high clock");

   AST_STOP_RELEASE: assert property (@(posedge clock) disable iff (rst)
      (state_ff == ST_STOP) && tick && (phase_ff == PH_FALL)
      |=> isIdle && sclOut_ff && !sdaLow_ff && $past(sdaLow_ff))
      else $error("stop condition did not release the bus");

   AST_DATA_STABLE_HIGH: assert property (@(posedge clock) disable iff (rst)
      (state_ff == ST_BIT) && sclOut_ff && $past(sclOut_ff) |-> $stable(sdaLow_ff))
      else $error("data line moved while clock high");

   AST_ACK_CAPTURE: assert property (@(posedge clock) disable iff (rst)
      (state_ff == ST_ACK) && !rdOp_ff && tick && (phase_ff == PH_SAMPLE)
      |=> ack_ff == !$past(sdaSync) ##1 status[ST_ACK_POS] == ack_ff)
      else $error("acknowledge not captured into status");

   AST_READ_DATA_OUT: assert property (@(posedge clock) disable iff (rst)
      (state_ff == ST_ACK) && rdOp_ff && tick && (phase_ff == PH_FALL)
      |=> (dataOut_ff == $past(shift_ff)) && isIdle)
      else $error("read byte not moved to data out");

   AST_SCL_HIGH_TIME: assert property (@(posedge clock) disable iff (rst)
      $fell(sclOut_ff) && ($past(state_ff) == ST_BIT) |-> sclHiCnt_ff == SCL_HIGH_CYC)
      else $error("bus clock high time differs from divider setting");

   AST_BUSY_DROPS: assert property (@(posedge clock) disable iff (rst)
      accept && !isIdle && !tick |=> drop_ff && $stable(state_ff))
      else $error("word taken while an operation was running");

endmodule

/* File: tb/s2i_slave_model.sv */
// Purpose: behavioural two-wire bus slave facing the bridge
// Assumes: the data line is resolved outside, with a pull-up
// Notes:   acks address and written bytes; serves rdByte when addressed for read
`timescale 1ns/1ps
module s2i_slave_model (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       ackEn,
   input  wire logic [7:0] rdByte,
   output logic            sdaOeN,
   output logic [7:0]      lastByte,
   output int              startCnt,
   output int              stopCnt
);
   logic [3:0] bitCnt;
   logic [7:0] shiftIn;
   logic       isAddr;
   logic       reading;
   logic       ackMine;

   initial begin
      sdaOeN = 1'b1;
      lastByte = 8'h00;
      startCnt = 0;
      stopCnt = 0;
      bitCnt = 4'h0;
      shiftIn = 8'h00;
      isAddr = 1'b0;
      reading = 1'b0;
      ackMine = 1'b0;
   end

   // =====================================================================
   // framing: start or repeated start, and stop
   always @(negedge sda) if (scl === 1'b1) begin
      startCnt++;
      bitCnt = 4'h0;
      isAddr = 1'b1;
      reading = 1'b0;
      sdaOeN = 1'b1;
   end
   always @(posedge sda) if (scl === 1'b1) begin
      stopCnt++;
      reading = 1'b0;
   end

   // =====================================================================
   // bit capture on clock rise, msb first
   always @(posedge scl) begin
      if (bitCnt < 4'h8) shiftIn = {shiftIn[6:0], sda};
      bitCnt++;
      if (bitCnt == 4'h8) begin
         ackMine = isAddr || !reading;
         if (ackMine) lastByte = shiftIn;
         if (isAddr) reading = shiftIn[0];
         isAddr = 1'b0;
      end else if (bitCnt == 4'h9) begin
         // master nack ends the read, so the line is freed for a stop
         if (reading && !ackMine && sda) reading = 1'b0;
         bitCnt = 4'h0;
      end
   end

   // change the line on clock fall, and release it at a start, so it holds steady across each high phase
   always @(negedge scl) begin
      if (bitCnt == 4'h8) sdaOeN = !(ackMine && ackEn);
      else if (reading && !isAddr) sdaOeN = rdByte[3'h7 - bitCnt[2:0]];
      else sdaOeN = 1'b1;
   end
endmodule

/* File: tb/tb.sv */
// Purpose: self-checking bench for the link to two-wire bus bridge
// Assumes: link mode 0, msb first; quarter bus clock shortened to 4 cycles
// Notes:   bench acts as link host; slave model sits on the bus
`timescale 1ns/1ps
module tb
   import s2i_pkg::*;
;
   localparam int unsigned DIV     = 4;
   localparam int          OP_WAIT = 200;  // 40 quarters of 4 cycles plus margin

   logic        clock;
   logic        rst;
   logic        spiClk;
   logic        ssN;
   logic        mosi;
   logic        miso;
   logic        sclOut;
   logic        sdaOut;
   logic        sdaOeN;
   logic        slvOeN;
   logic        ackEn;
   logic [7:0]  rdByte;
   logic [7:0]  lastByte;
   int          startCnt;
   int          stopCnt;
   logic [15:0] rx;
   int          err_total;
   int          cmp_count;
   wire logic   sdaWire;

   // open-drain data line with pull-up
   assign sdaWire = (sdaOeN ? 1'b1 : sdaOut) & slvOeN;

   s2i_bridge #(.CLK_DIV(DIV)) uut (
      .clock(clock), .rst(rst), .spiClk(spiClk), .ssN(ssN), .mosi(mosi), .miso(miso),
      .sclOut(sclOut), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN));

   s2i_slave_model slave (
      .scl(sclOut), .sda(sdaWire), .ackEn(ackEn), .rdByte(rdByte), .sdaOeN(slvOeN),
      .lastByte(lastByte), .startCnt(startCnt), .stopCnt(stopCnt));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // =====================================================================
   // tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         err_total++;
      end
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one link word; link clock runs only inside the frame
   task automatic xfer(input logic [15:0] tx, input int nBits, output logic [15:0] got);
      got = 16'h0000;
      @(posedge clock);
      ssN <= 1'b0;
      #4.3;
      for (int i = 0; i < nBits; i++) begin
         mosi = tx[15 - i];
         // host takes miso just before its rising edge, ahead of the counter step
         #15 got = {got[14:0], miso};
         spiClk = 1'b1;
         #15 spiClk = 1'b0;
      end
      #7;
      @(posedge clock);
      ssN <= 1'b1;
      mosi <= 1'b0;
   endtask

   // word then the host's gap until the bus operation is over
   task automatic op(input logic [7:0] cmd, input logic [7:0] dat);
      xfer({cmd, dat}, 16, rx);
      repeat (OP_WAIT) @(posedge clock);
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      end_of_test();
   end

   // =====================================================================
   // main sequence
   initial begin
      rst = 1'b1;
      ssN = 1'b1;
      spiClk = 1'b0;
      mosi = 1'b0;
      ackEn = 1'b1;
      rdByte = 8'hc3;
      err_total = 0;
      cmp_count = 0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      check("idle pins", {sclOut, sdaOeN}, 16'h0003);
      // start with write address, then a data byte
      op(CMD_START, 8'ha4);
      check("starts", 16'(startCnt), 16'h0001);
      check("address", {8'h00, lastByte}, 16'h00a4);
      op(CMD_WRITE, 8'h5a);
      check("written", {8'h00, lastByte}, 16'h005a);
      op(CMD_NULL, 8'h00);
      check("ack status", rx, 16'h0100);
      // repeated start for read, one byte read, collected by null
      op(CMD_START, 8'ha5);
      check("restart", 16'(startCnt), 16'h0002);
      op(CMD_READ, 8'hff);
      op(CMD_NULL, 8'h00);
      check("read data", rx, 16'h01c3);
      // address not acknowledged
      ackEn = 1'b0;
      op(CMD_START, 8'ha4);
      op(CMD_NULL, 8'h00);
      check("nack status", rx, 16'h00c3);
      ackEn = 1'b1;
      op(CMD_STOP, 8'h00);
      check("stops", 16'(stopCnt), 16'h0001);
      check("bus free", {sclOut, sdaOeN}, 16'h0003);
      // null must leave the bus alone
      op(CMD_NULL, 8'h00);
      check("null word", rx, 16'h00c3);
      check("null bus", {16'(startCnt)}, 16'h0003);
      check("null stop", 16'(stopCnt), 16'h0001);
      // short word is ignored
      xfer({CMD_START, 8'ha4}, 8, rx);
      repeat (OP_WAIT) @(posedge clock);
      check("short word", 16'(startCnt), 16'h0003);
      // unknown command acts as null and is flagged
      op(8'h81, 8'h00);
      check("unknown bus", 16'(startCnt), 16'h0003);
      op(CMD_NULL, 8'h00);
      check("unknown flag", rx, 16'h02c3);
      // word while busy is dropped
      xfer({CMD_START, 8'ha4}, 16, rx);
      repeat (10) @(posedge clock);
      xfer({CMD_NULL, 8'h00}, 16, rx);
      check("busy bit", {15'h0000, rx[15]}, 16'h0001);
      repeat (OP_WAIT) @(posedge clock);
      op(CMD_NULL, 8'h00);
      check("drop flag", rx, 16'h05c3);
      check("last start", 16'(startCnt), 16'h0004);
      end_of_test();
   end
endmodule
